// ### src/odl_loader.sv
// Display memory, command interpreter and cell output stage.
// Contract
// - Display memory has 256 words of 13 bits, addressed by 8-bit pointer.
// - Word bits 12..5 hold character, bits 4..0 hold attribute.
// - Character codes 00H to FCH select a glyph by that code.
// - Glyph word: attribute 4..1 is foreground colour, bit 0 enables blink.
// - Code FDH is a reserved test code, not glyph, break or space.
// - Code FEH is a line break showing a transparent cell.
// - Break word: bits 4..3 next row size, bits 2..1 row spacing.
// - Break word bit 0 ends the current screen early.
// - Code FFH is a space, one transparent cell wide.
// - Space word bits 4..1 give background colour for following characters.
// - Space word bit 0 enables record mark output for following characters.
// - During retrace colour, intensity, blank and record mark outputs stay inactive.
// - High address command loads pointer bits 7..4, low command bits 3..0.
// - Attribute command captures five bits; staging bits 7..5 unused.
// - Font command captures seven character bits; the bank supplies the top bit of word bits 12..5.
// - Either font command writes staged attribute and the new character at pointer.
// - Each memory write advances the pointer by one.
// - Attribute staging is kept across writes for repeated attributes.
// - Glyphs are 12 by 19; row 0 only shows in diagonal shadow mode.
// - Glyph bit one is a visible dot, zero is blank.
// - Two-bit command bank, reset to zero, qualifies command decoding.
// - Address commands carry their pointer nibble in the low nibble.
// - Attribute command writes its low five bits to the staging register.
`timescale 1ns/10ps
module odl_loader #(
  parameter int FIFO_D = odl_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [4:0] rd_row,
  input wire logic [3:0] rd_col,
  input wire logic diag_mode,
  input wire logic blink_phase,
  input wire logic retrace_pin,
  output logic [12:0] glyph_addr_reg,
  input wire logic [11:0] glyph_bits,
  output logic [3:0] rgbi_reg,
  output logic fast_blank_out_reg,
  output logic record_mark_monitor_reg,
  output logic [3:0] bg_colour_reg,
  output logic line_break_reg,
  output logic [1:0] char_size_reg,
  output logic [1:0] line_spacing_reg,
  output logic end_of_display_reg,
  output logic [7:0] display_write_pointer,
  output logic [1:0] cmd_bank_reg
);
  logic [12:0] disp_mem [odl_pkg::DEPTH];
  logic [7:0] display_char_staging;
  logic [4:0] display_attr_staging;
  logic fifo_valid;
  logic [7:0] fifo_byte;
  logic take;
  logic bank_cmd;
  logic font_cmd;
  logic attr_cmd;
  logic hi_cmd;
  logic lo_cmd;
  logic [7:0] char_next;
  logic retrace_s1_reg;
  logic retrace_reg;
  logic [12:0] word_reg;
  logic word_vld_reg;
  logic [4:0] row1_reg;
  logic [3:0] col1_reg;
  odl_pkg::odl_word_t dec1;
  odl_pkg::odl_word_t f2_reg;
  logic vld2_reg;
  logic [4:0] row2_reg;
  logic [3:0] col2_reg;
  logic acm_en_reg;
  logic dot;

  // Incoming command bytes are queued; the queue drains only when the
  // memory port is not used by the read side, so bursts back up to the source.
  odl_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(cmd_valid),
    .in_data(cmd_byte),
    .in_ready(cmd_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_byte),
    .out_ready(!rd_en)
  );

  assign take = fifo_valid && !rd_en;

  // Command decode qualified by the current bank.
  always_comb begin
    bank_cmd = take && (fifo_byte[7:2] == odl_pkg::OP_BANK);
    font_cmd = take && fifo_byte[7] &&
      ((cmd_bank_reg == odl_pkg::BANK_MAIN) || (cmd_bank_reg == odl_pkg::BANK_FONT_HI));
    attr_cmd = take && (fifo_byte[7:5] == odl_pkg::OP_ATTR) && !cmd_bank_reg[0];
    hi_cmd = take && (fifo_byte[7:4] == odl_pkg::OP_ADDR_HI) && (cmd_bank_reg == odl_pkg::BANK_MAIN);
    lo_cmd = take && (fifo_byte[7:4] == odl_pkg::OP_ADDR_LO) && (cmd_bank_reg == odl_pkg::BANK_MAIN);
    // Bank 2 font command supplies the top character bit set.
    char_next = {cmd_bank_reg[1], fifo_byte[6:0]};
  end

  // Command bank selector.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_bank_reg <= odl_pkg::BANK_RESET;
    end else if (bank_cmd) begin
      cmd_bank_reg <= fifo_byte[1:0];
    end
  end

  // Write pointer: nibble loads and post-write increment.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      display_write_pointer <= odl_pkg::PTR_RESET;
    end else if (font_cmd) begin
      display_write_pointer <= display_write_pointer + 8'h01;
    end else if (hi_cmd) begin
      display_write_pointer[7:4] <= fifo_byte[3:0];
    end else if (lo_cmd) begin
      display_write_pointer[3:0] <= fifo_byte[3:0];
    end
  end

  // Staging registers; attributes persist until reloaded.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      display_attr_staging <= odl_pkg::ATTR_RESET;
      display_char_staging <= odl_pkg::CHAR_RESET;
    end else begin
      if (attr_cmd) display_attr_staging <= fifo_byte[4:0];
      if (font_cmd) display_char_staging <= char_next;
    end
  end

  // Memory write uses the fresh character byte and held attribute.
  always_ff @(posedge core_clk) begin
    if (font_cmd) begin
      disp_mem[display_write_pointer] <= {char_next, display_attr_staging};
    end
  end

  // Retrace arrives from a pin and is synchronised before use.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      retrace_s1_reg <= 1'b0;
      retrace_reg <= 1'b0;
    end else begin
      retrace_s1_reg <= retrace_pin;
      retrace_reg <= retrace_s1_reg;
    end
  end

  // Stage 1: memory read with row and column carried along.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word_vld_reg <= 1'b0;
      row1_reg <= '0;
      col1_reg <= '0;
    end else begin
      word_vld_reg <= rd_en;
      row1_reg <= rd_row;
      col1_reg <= rd_col;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rd_en) word_reg <= disp_mem[rd_addr];
  end

  odl_word_dec u_dec (
    .word(word_reg),
    .dec(dec1)
  );

  // Stage 2: glyph store address and row-level attributes.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      f2_reg <= '0;
      vld2_reg <= 1'b0;
      row2_reg <= '0;
      col2_reg <= '0;
      glyph_addr_reg <= '0;
      line_break_reg <= 1'b0;
      char_size_reg <= '0;
      line_spacing_reg <= '0;
      end_of_display_reg <= 1'b0;
    end else begin
      f2_reg <= dec1;
      vld2_reg <= word_vld_reg;
      row2_reg <= row1_reg;
      col2_reg <= col1_reg;
      glyph_addr_reg <= {dec1.code, row1_reg};
      line_break_reg <= word_vld_reg && (dec1.fmt == odl_pkg::ODL_FMT_CR);
      end_of_display_reg <= word_vld_reg && dec1.end_disp;
      if (word_vld_reg && (dec1.fmt == odl_pkg::ODL_FMT_CR)) begin
        char_size_reg <= dec1.size;
        line_spacing_reg <= dec1.spacing;
      end
    end
  end

  // Space words set background and record marking for what follows.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bg_colour_reg <= '0;
      acm_en_reg <= 1'b0;
    end else if (vld2_reg && (f2_reg.fmt == odl_pkg::ODL_FMT_SPACE)) begin
      bg_colour_reg <= f2_reg.colour;
      acm_en_reg <= f2_reg.acm_en;
    end
  end

  // A dot is visible for a one bit in a real column; row 0 only joins glyphs
  // in diagonal shadowing, so it is blank otherwise.
  always_comb begin
    dot = 1'b0;
    if ((col2_reg < 4'(odl_pkg::GLYPH_W)) && (row2_reg < 5'(odl_pkg::GLYPH_ROWS))) begin
      dot = glyph_bits[4'(odl_pkg::GLYPH_W - 1) - col2_reg];
      if ((row2_reg == 5'h00) && !diag_mode) dot = 1'b0;
    end
  end

  // Stage 3: cell outputs; retrace forces every video output inactive.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rgbi_reg <= '0;
      fast_blank_out_reg <= 1'b0;
      record_mark_monitor_reg <= 1'b0;
    end else if (retrace_reg) begin
      rgbi_reg <= '0;
      fast_blank_out_reg <= 1'b0;
      record_mark_monitor_reg <= 1'b0;
    end else if (vld2_reg && (f2_reg.fmt == odl_pkg::ODL_FMT_FONT) && dot &&
                 !(f2_reg.blink && blink_phase)) begin
      rgbi_reg <= f2_reg.colour;
      fast_blank_out_reg <= 1'b1;
      record_mark_monitor_reg <= acm_en_reg;
    end else begin
      // Test, break and space cells are transparent.
      rgbi_reg <= '0;
      fast_blank_out_reg <= 1'b0;
      record_mark_monitor_reg <= 1'b0;
    end
  end

  // Checks kept next to the logic above.
  sequence font_take_s;
    font_cmd;
  endsequence

  sequence retrace_s;
    retrace_reg;
  endsequence

  ptr_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
    font_take_s |=> display_write_pointer == $past(display_write_pointer) + 8'h01)
    else $error("pointer did not advance after write");

  ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (font_cmd && display_write_pointer == 8'hFF) |=> display_write_pointer == 8'h00)
    else $error("pointer did not wrap");

  ptr_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
    hi_cmd |=> (display_write_pointer[7:4] == $past(fifo_byte[3:0])) &&
      (display_write_pointer[3:0] == $past(display_write_pointer[3:0])))
    else $error("high nibble load wrong");

  ptr_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
    lo_cmd |=> (display_write_pointer[3:0] == $past(fifo_byte[3:0])) &&
      (display_write_pointer[7:4] == $past(display_write_pointer[7:4])))
    else $error("low nibble load wrong");

  attr_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    attr_cmd |=> display_attr_staging == $past(fifo_byte[4:0]))
    else $error("attribute staging not loaded");

  attr_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (font_take_s ##1 !attr_cmd) |=> $stable(display_attr_staging))
    else $error("attribute staging changed without command");

  mem_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    font_take_s |=> disp_mem[$past(display_write_pointer)] ==
      {$past(char_next), $past(display_attr_staging)})
    else $error("memory word not written");

  bank_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (take && fifo_byte[7:4] == odl_pkg::OP_ADDR_HI && cmd_bank_reg != 2'h0)
      |=> $stable(display_write_pointer))
    else $error("address command taken in wrong bank");

  retrace_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    retrace_s ##1 retrace_s |-> (rgbi_reg == 4'h0) && !fast_blank_out_reg &&
      !record_mark_monitor_reg)
    else $error("video active during retrace");

  // A bank command replaces the whole selector with its low two bits.
  bank_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    bank_cmd |=> cmd_bank_reg == $past(fifo_byte[1:0]))
    else $error("bank selector not loaded");

  // The glyph store address pairs the stored code with the requested row.
  glyph_addr_a: assert property (@(posedge core_clk) disable iff (!rstn)
    word_vld_reg |=> glyph_addr_reg == {$past(word_reg[12:odl_pkg::CHAR_LSB]), $past(row1_reg)})
    else $error("glyph address mismatch");

  // Test, break and space cells never light a dot.
  cell_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (vld2_reg && (f2_reg.fmt != odl_pkg::ODL_FMT_FONT)) |=>
      !fast_blank_out_reg && (rgbi_reg == 4'h0))
    else $error("transparent cell drove video");

  // Character staging follows each font command, bank bit included.
  char_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    font_take_s |=> display_char_staging == $past(char_next))
    else $error("character staging not loaded");

  // Row size and spacing only move on a line-break word, so later rows keep them.
  row_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(word_vld_reg && (dec1.fmt == odl_pkg::ODL_FMT_CR)) |=>
      $stable(char_size_reg) && $stable(line_spacing_reg))
    else $error("row size changed without break");

  // Background and marking stay put between space words.
  bg_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(vld2_reg && (f2_reg.fmt == odl_pkg::ODL_FMT_SPACE)) |=>
      $stable(bg_colour_reg) && $stable(acm_en_reg))
    else $error("background changed without space");
endmodule // odl_loader

// ### src/odl_pkg.sv
// Shared constants and carrier types for the display memory loader.
package odl_pkg;
  localparam int DEPTH = 256;
  localparam int AW = 8;
  localparam int WW = 13;
  localparam int CHAR_LSB = 5;
  localparam int ATTR_W = 5;
  localparam int GLYPH_W = 12;
  localparam int GLYPH_ROWS = 19;
  localparam int FIFO_DEPTH = 8;
  // Character field codes.
  localparam logic [7:0] CODE_FONT_MAX = 8'hFC;
  localparam logic [7:0] CODE_TEST = 8'hFD;
  localparam logic [7:0] CODE_CR = 8'hFE;
  localparam logic [7:0] CODE_SPACE = 8'hFF;
  // Command banks and opcode patterns.
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [1:0] BANK_MAIN = 2'h0;
  localparam logic [1:0] BANK_FONT_HI = 2'h2;
  localparam logic [5:0] OP_BANK = 6'h1E;
  localparam logic [2:0] OP_ATTR = 3'h0;
  localparam logic [3:0] OP_ADDR_HI = 4'h2;
  localparam logic [3:0] OP_ADDR_LO = 4'h3;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [4:0] ATTR_RESET = 5'h00;
  localparam logic [7:0] CHAR_RESET = 8'h00;

  typedef enum logic [1:0] {
    ODL_FMT_FONT = 2'b00,
    ODL_FMT_TEST = 2'b01,
    ODL_FMT_CR = 2'b10,
    ODL_FMT_SPACE = 2'b11
  } odl_fmt_t;

  // Decoded display word.
  typedef struct packed {
    odl_fmt_t fmt;
    logic [7:0] code;
    logic [3:0] colour;
    logic blink;
    logic [1:0] size;
    logic [1:0] spacing;
    logic end_disp;
    logic acm_en;
  } odl_word_t;
endpackage

// ### src/odl_fifo.sv
// Command byte FIFO with registered ready and honest full and empty.
`timescale 1ns/10ps
module odl_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic [PW:0] cnt_next;
  logic push;
  logic pop;

  // Ready is a flop, so a full FIFO refuses the very next byte.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointers, fill count and ready.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wp_reg <= (wp_reg == PW'(D - 1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == PW'(D - 1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next < (PW + 1)'(D));
    end
  end

  // Storage carries no reset; only written slots are ever read.
  always_ff @(posedge core_clk) begin
    if (push) mem_reg[wp_reg] <= in_data;
  end

  full_refuse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (cnt_reg == (PW + 1)'(D)) |-> !in_ready)
    else $error("fifo full but ready");
endmodule // odl_fifo

// ### src/odl_word_dec.sv
// Classifies a display word and splits its attribute field by format.
`timescale 1ns/10ps
module odl_word_dec (
  input wire logic [12:0] word,
  output odl_pkg::odl_word_t dec
);
  logic [7:0] code;
  logic [4:0] attr;

  assign code = word[12:odl_pkg::CHAR_LSB];
  assign attr = word[odl_pkg::ATTR_W-1:0];

  // Format follows the character field; fields other than end_disp are decoded for every
  // format and consumers only look at those that match.
  always_comb begin
    dec = '0;
    dec.code = code;
    if (code <= odl_pkg::CODE_FONT_MAX) begin
      dec.fmt = odl_pkg::ODL_FMT_FONT;
    end else if (code == odl_pkg::CODE_TEST) begin
      dec.fmt = odl_pkg::ODL_FMT_TEST;
    end else if (code == odl_pkg::CODE_CR) begin
      dec.fmt = odl_pkg::ODL_FMT_CR;
    end else begin
      dec.fmt = odl_pkg::ODL_FMT_SPACE;
    end
    dec.colour = attr[4:1];
    dec.blink = attr[0];
    dec.size = attr[4:3];
    dec.spacing = attr[2:1];
    dec.end_disp = (dec.fmt == odl_pkg::ODL_FMT_CR) && attr[0];
    dec.acm_en = attr[0];
  end
endmodule // odl_word_dec

// ### bench/odl_mcu_model.sv
// Behavioural microcontroller that feeds command bytes to the display memory loader.
`timescale 1ns/10ps
module odl_mcu_model (
  input wire logic core_clk,
  input wire logic rstn,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic cmd_ready
);
  int gap = 0;

  // Idle bus at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
  end

  // Offers one byte and holds it until taken; a released byte line shows the inverse so stale data never matches.
  task automatic send(input logic [7:0] b);
    logic r;
    wait (rstn === 1'b1);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte = b;
    do begin
      @(negedge core_clk);
      r = cmd_ready;
      @(posedge core_clk);
    end while (r !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  endtask

  // Sets the start location, high nibble command first, then low nibble command.
  task automatic set_ptr(input logic [7:0] a);
    send({odl_pkg::OP_ADDR_HI, a[7:4]});
    send({odl_pkg::OP_ADDR_LO, a[3:0]});
  endtask

  task automatic set_attr(input logic [4:0] t);
    send({odl_pkg::OP_ATTR, t});
  endtask

  task automatic font(input logic [7:0] c);
    send({1'b1, c[6:0]});
  endtask

  task automatic bank(input logic [1:0] bs);
    send({odl_pkg::OP_BANK, bs});
  endtask
endmodule // odl_mcu_model

// ### bench/osd_display_ram_loader_tb_top.sv
// Self-checking testbench for the display memory loader.
`timescale 1ns/10ps
module osd_display_ram_loader_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_ready, rd_en, diag_mode, blink_phase, retrace_pin;
  logic [7:0] cmd_byte, rd_addr, ptr;
  logic [4:0] rd_row;
  logic [3:0] rd_col;
  logic [12:0] glyph_addr_reg, g_addr;
  logic [11:0] glyph_bits;
  logic [3:0] rgbi_reg, bg_colour_reg, rgbi, bg;
  logic fast_blank_out_reg, record_mark_monitor_reg, line_break_reg, end_of_display_reg;
  logic [1:0] char_size_reg, line_spacing_reg, cmd_bank_reg, sz, sp;
  logic lb, eod, fb, rm;
  int miscompares = 0;
  int samples_checked = 0;

  always #25 core_clk = ~core_clk;

  // Glyph store stand-in: rows 0 and 1 show the inverted code in columns 0 to 7, rows 2 and 3 are blank.
  // Tying the code into the pattern lets a wrong column select show up as a wrong dot.
  assign glyph_bits = glyph_addr_reg[1] ? 12'h000 : ~{glyph_addr_reg[12:5], 4'h0};

  odl_mcu_model u_odl_mcu_model (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready));

  odl_loader u_odl_loader (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rd_en(rd_en), .rd_addr(rd_addr), .rd_row(rd_row),
    .rd_col(rd_col), .diag_mode(diag_mode), .blink_phase(blink_phase), .retrace_pin(retrace_pin),
    .glyph_addr_reg(glyph_addr_reg), .glyph_bits(glyph_bits), .rgbi_reg(rgbi_reg),
    .fast_blank_out_reg(fast_blank_out_reg), .record_mark_monitor_reg(record_mark_monitor_reg),
    .bg_colour_reg(bg_colour_reg), .line_break_reg(line_break_reg), .char_size_reg(char_size_reg),
    .line_spacing_reg(line_spacing_reg), .end_of_display_reg(end_of_display_reg),
    .display_write_pointer(ptr), .cmd_bank_reg(cmd_bank_reg));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Polls the pointer under a bounded count, since drain latency depends on the queue.
  task automatic wait_ptr(input logic [7:0] e);
    for (int i = 0; i < 20 && ptr !== e; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("pointer", {8'h00, e}, {8'h00, ptr});
  endtask

  // Writes one word; codes with bit 7 set need the upper font bank.
  task automatic put(input logic [7:0] a, input logic [7:0] c, input logic [4:0] t);
    u_odl_mcu_model.set_ptr(a);
    u_odl_mcu_model.set_attr(t);
    if (c[7]) u_odl_mcu_model.bank(2'h2);
    u_odl_mcu_model.font(c);
    if (c[7]) u_odl_mcu_model.bank(2'h0);
    wait_ptr(a + 8'h01);
  endtask

  // One-cycle read; decode outputs land two edges later, cell outputs three.
  // The view mode is {diagonal shadowing, blink phase} and holds until the next read.
  task automatic rd(input logic [7:0] a, input logic [4:0] r, input logic [3:0] k, input logic [1:0] vm = 2'b00);
    @(posedge core_clk);
    #1;
    {diag_mode, blink_phase} = vm;
    rd_en = 1'b1;
    rd_addr = a;
    rd_row = r;
    rd_col = k;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    @(posedge core_clk);
    #1;
    g_addr = glyph_addr_reg;
    lb = line_break_reg;
    eod = end_of_display_reg;
    sz = char_size_reg;
    sp = line_spacing_reg;
    @(posedge core_clk);
    #1;
    rgbi = rgbi_reg;
    fb = fast_blank_out_reg;
    rm = record_mark_monitor_reg;
    bg = bg_colour_reg;
  endtask

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  initial begin
    {rd_en, retrace_pin} = 2'h0;
    rd_addr = 8'h00;
    rd_row = 5'h00;
    rd_col = 4'h0;
    repeat (5) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("pointer", 16'h0000, {8'h00, ptr});
    chk("bank", 16'h0000, {14'h0000, cmd_bank_reg});
    chk("ready", 16'h0001, {15'h0000, cmd_ready});
    put(8'h5A, 8'h41, 5'h13);
    u_odl_mcu_model.gap = 3;
    u_odl_mcu_model.font(8'h42);
    u_odl_mcu_model.gap = 0;
    wait_ptr(8'h5C);
    rd(8'h5A, 5'h01, 4'h0);
    chk("glyph address", {3'h0, 8'h41, 5'h01}, {3'h0, g_addr});
    chk("colour", 16'h0009, {12'h000, rgbi});
    chk("dot", 16'h0001, {15'h0000, fb});
    rd(8'h5B, 5'h01, 4'h3);
    chk("kept colour", 16'h0009, {12'h000, rgbi});
    rd(8'h5A, 5'h02, 4'h0);
    chk("blank dot", 16'h0000, {15'h0000, fb});
    rd(8'h5A, 5'h01, 4'h1);
    chk("blank column", 16'h0000, {15'h0000, fb});
    rd(8'h5A, 5'h00, 4'h0);
    chk("row zero", 16'h0000, {15'h0000, fb});
    rd(8'h5A, 5'h00, 4'h0, 2'b10);
    chk("row zero diag", 16'h0001, {15'h0000, fb});
    rd(8'h5A, 5'h01, 4'h0, 2'b01);
    chk("blink off", 16'h0000, {15'h0000, fb});
    put(8'h10, 8'hFE, 5'h1F);
    rd(8'h10, 5'h01, 4'h0);
    chk("break", 16'h0001, {15'h0000, lb});
    chk("break cell", 16'h0000, {15'h0000, fb});
    chk("size spacing", 16'h000F, {12'h000, sz, sp});
    chk("end", 16'h0001, {15'h0000, eod});
    put(8'h11, 8'hFE, 5'h0A);
    rd(8'h11, 5'h01, 4'h0);
    chk("size spacing", 16'h0005, {12'h000, sz, sp});
    chk("end", 16'h0000, {15'h0000, eod});
    put(8'h12, 8'hFF, 5'h1B);
    rd(8'h12, 5'h01, 4'h0);
    chk("space cell", 16'h0000, {15'h0000, fb});
    chk("background", 16'h000D, {12'h000, bg});
    rd(8'h5A, 5'h01, 4'h0);
    chk("mark on", 16'h0001, {15'h0000, rm});
    put(8'h13, 8'hFF, 5'h1A);
    rd(8'h13, 5'h01, 4'h0);
    rd(8'h5A, 5'h01, 4'h0);
    chk("mark off", 16'h0000, {15'h0000, rm});
    put(8'h14, 8'hFD, 5'h1F);
    rd(8'h14, 5'h01, 4'h0);
    chk("test cell", 16'h0000, {14'h0000, lb, fb});
    u_odl_mcu_model.bank(2'h1);
    u_odl_mcu_model.set_ptr(8'h33);
    repeat (12) @(posedge core_clk);
    chk("other bank", 16'h0015, {8'h00, ptr});
    chk("bank", 16'h0001, {14'h0000, cmd_bank_reg});
    u_odl_mcu_model.bank(2'h0);
    retrace_pin = 1'b1;
    repeat (4) @(posedge core_clk);
    rd(8'h5A, 5'h01, 4'h0);
    chk("retrace", 16'h0000, {11'h000, rgbi, fb});
    retrace_pin = 1'b0;
    put(8'hFF, 8'h07, 5'h02);
    rd(8'hFF, 5'h01, 4'h0);
    chk("last word", {3'h0, 8'h07, 5'h01}, {3'h0, g_addr});
    chk("colour", 16'h0001, {12'h000, rgbi});
    // Reads stall draining, so the queue fills until it refuses.
    @(posedge core_clk);
    #1;
    rd_en = 1'b1;
    repeat (6) u_odl_mcu_model.set_attr(5'h00);
    u_odl_mcu_model.set_ptr(8'h80);
    chk("full", 16'h0000, {15'h0000, cmd_ready});
    chk("stalled", 16'h0000, {8'h00, ptr});
    rd_en = 1'b0;
    wait_ptr(8'h80);
    chk("ready", 16'h0001, {15'h0000, cmd_ready});
    finish_test();
  end
endmodule // osd_display_ram_loader_tb_top
